// >>> include/tamper_cfg.svh
// Register offsets, field positions, reset values and sizes for tamper ctrl
`ifndef TAMPER_CFG_SVH
`define TAMPER_CFG_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_FREQ 8'h04
`define OFF_VOLT 8'h08
`define OFF_TEMP 8'h0c
`define OFF_STAT 8'h10
// Control register bit positions
`define BIT_FREQ_EN 0
`define BIT_TEMP_EN 1
`define BIT_CORE_EN 2
`define BIT_MGR_EN 3
`define BIT_DET_PIN 4
`define BIT_ZERO_PIN 5
`define BIT_RESP_CLEAN 6
`define CTRL_W 7
// Reset values
`define RST_CTRL 7'h00
`define RST_FREQ 8'h0a
`define RST_VOLT 8'h05
`define RST_TEMP_LO 8'h00
`define RST_TEMP_HI 8'hff
// Sizes
`define MON_W 8
`define CTRL_N 3
`endif

// >>> include/tamper_pkg.sv
// Types shared by the tamper response controller
package tamper_pkg;
  // Response sequence states
  typedef enum {StIdle, StClean, StWait, StReport, StStop} tamper_state_t;
endpackage

// >>> include/zeroize_if.sv
// Command and summary link between response FSM and zeroize sequencer
`timescale 1ns/1ps
interface zeroize_if;
  logic start;
  logic allDone;
  logic allPass;
  modport ctl (output start, input allDone, input allPass);
  modport seq (input start, output allDone, output allPass);
endinterface // zeroize_if

// >>> hdl/zeroize_sequencer.sv
// Per memory controller zeroize command and status recorder
`timescale 1ns/1ps
`include "tamper_cfg.svh"
module zeroize_sequencer #(
  parameter int N = `CTRL_N
)(
  input wire logic clk,
  input wire logic resetn,
  zeroize_if.seq zb,
  output logic [N-1:0] memStart,
  input wire logic [N-1:0] memDone,
  input wire logic [N-1:0] memPass
);
  logic [N-1:0] done_q;
  logic [N-1:0] pass_q;

  // ----------------------------------------------------------------
  // Per controller command and status
  // ----------------------------------------------------------------
  genvar i;
  for (i = 0; i < N; i++) begin : g_ctl
    // R21: command each controller
    always_ff @(posedge clk) begin
      if (!resetn) begin
        memStart[i] <= 1'b0;
      end else if (zb.start) begin
        memStart[i] <= 1'b1;
      end else if (memDone[i]) begin
        memStart[i] <= 1'b0;
      end
    end
    // R20: record write and read-back verdict
    always_ff @(posedge clk) begin
      if (!resetn) begin
        done_q[i] <= 1'b0;
        pass_q[i] <= 1'b0;
      end else if (memStart[i] && memDone[i]) begin
        done_q[i] <= 1'b1;
        pass_q[i] <= memPass[i];
      end
    end
  end

  // R22: verified memories summarised here
  assign zb.allDone = &done_q;
  assign zb.allPass = &pass_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cmd;
    @(posedge clk) disable iff (!resetn)
    zb.start |=> (memStart == {N{1'b1}});
  endproperty
  a_cmd: assert property (p_cmd) else $error("zeroize not commanded"); // R21
  property p_rec;
    @(posedge clk) disable iff (!resetn)
    (memStart[0] && memDone[0]) |=> done_q[0] && pass_q[0] == $past(memPass[0]);
  endproperty
  a_rec: assert property (p_rec) else $error("status not recorded"); // R20
endmodule // zeroize_sequencer

// >>> hdl/tamper_response_controller.sv
// Anti-tamper monitor, response sequencer and APB register file
`timescale 1ns/1ps
// What this block does
// R1: Detect pin rises on any enabled violation
// R2: Done pin confirms successful response
// R3: Both pins stick until power-on reset
// R4: Monitor clock, two rails, die temperature
// R5: Frequency check only when enabled, percentage
// R6: Temperature check against lower, upper bound
// R7: Per-rail enables, percentage deviation trigger
// R8: Settings loaded, kept until next load
// R9: Response ends in stopped state
// R10: Response level is clean or disabled
// R11: Erase fabric configuration and processor RAM
// R12: Abort operations, clear key vault
// R13: Done pin only on full pass, enabled
// R14: Disable manager security features
// R15: Config status low while clearing
// R16: Command memory controllers to zeroize
// R17: Clear battery-backed key RAM
// R18: Finally gate data and control clocks
// R19: Disabled level: no action, pin still
// R20: Zeroize means write then verify read-back
// R21: Command each controller, record its status
// R22: Verified memories versus clear-only registers
// R23: Ordered steps, report only if all pass
`include "tamper_cfg.svh"
module tamper_response_controller
  import tamper_pkg::*;
#(
  parameter int W = `MON_W,
  parameter int N = `CTRL_N
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [W-1:0] refClkDev,
  input wire logic [W-1:0] coreRailDev,
  input wire logic [W-1:0] mgrRailDev,
  input wire logic [W-1:0] dieTemp,
  output logic [N-1:0] memZeroStart,
  input wire logic [N-1:0] memZeroDone,
  input wire logic [N-1:0] memZeroPass,
  output logic abortOps,
  output logic keyVaultClear,
  output logic keyRamClear,
  output logic regClear,
  output logic securityOff,
  output logic tamperDetectOut,
  output logic zeroizeDoneOut,
  output logic configStatusN,
  output logic dataClkEn,
  output logic ctrlClkEn
);
  tamper_state_t state_q;
  logic [`CTRL_W-1:0] ctrl_q;
  logic [W-1:0] freqPct_q;
  logic [W-1:0] voltPct_q;
  logic [W-1:0] tempLo_q;
  logic [W-1:0] tempHi_q;
  logic detect_q;
  logic zeroOk_q;
  logic clean_q;
  logic startCmd_q;
  logic freqBad, tempBad, coreBad, mgrBad, violation;
  logic wrAcc, wrOk, setup;
  logic [31:0] rdWord;

  zeroize_if zb();

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_CTRL) || (a == `OFF_FREQ) || (a == `OFF_VOLT) ||
             (a == `OFF_TEMP) || (a == `OFF_STAT);
  endfunction

  function automatic logic writable(input logic [7:0] a);
    writable = mapped(a) && (a != `OFF_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // R5: frequency deviation check
  assign freqBad = ctrl_q[`BIT_FREQ_EN] && (refClkDev > freqPct_q);
  // R6: temperature window check
  assign tempBad = ctrl_q[`BIT_TEMP_EN] &&
                   ((dieTemp < tempLo_q) || (dieTemp > tempHi_q));
  // R7: per-rail voltage checks
  assign coreBad = ctrl_q[`BIT_CORE_EN] && (coreRailDev > voltPct_q);
  assign mgrBad = ctrl_q[`BIT_MGR_EN] && (mgrRailDev > voltPct_q);
  // R4: any monitor trips the response
  assign violation = freqBad || tempBad || coreBad || mgrBad;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; read data captured in setup phase
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  // R8: settings only load while idle
  assign wrOk = writable(paddr) && (state_q == StIdle);
  assign pslverr = psel && penable &&
                   (pwrite ? !wrOk : !mapped(paddr));

  // Read word selection
  always_comb begin
    rdWord = 32'h0;
    case (paddr)
      `OFF_CTRL: rdWord = 32'(ctrl_q);
      `OFF_FREQ: rdWord = 32'(freqPct_q);
      `OFF_VOLT: rdWord = 32'(voltPct_q);
      `OFF_TEMP: rdWord = 32'({tempHi_q, tempLo_q});
      `OFF_STAT: rdWord = {24'h0, freqBad, tempBad, coreBad, mgrBad,
                           state_q == StStop, !configStatusN,
                           zeroOk_q, detect_q};
      default: rdWord = 32'h0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rdWord;
    end
  end

  // R8: configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= `RST_CTRL;
      freqPct_q <= W'(`RST_FREQ);
      voltPct_q <= W'(`RST_VOLT);
      tempLo_q <= W'(`RST_TEMP_LO);
      tempHi_q <= W'(`RST_TEMP_HI);
    end else if (wrAcc && wrOk) begin
      case (paddr)
        `OFF_CTRL: ctrl_q <= pwdata[`CTRL_W-1:0];
        `OFF_FREQ: freqPct_q <= pwdata[W-1:0];
        `OFF_VOLT: voltPct_q <= pwdata[W-1:0];
        `OFF_TEMP: begin
          tempLo_q <= pwdata[W-1:0];
          tempHi_q <= pwdata[2*W-1:W];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Response sequence
  // ----------------------------------------------------------------
  // R23: ordered cleaning steps
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= StIdle;
    end else begin
      case (state_q)
        // R10: clean level starts response, R19: disabled stays
        StIdle: if (violation && ctrl_q[`BIT_RESP_CLEAN]) begin
          state_q <= StClean;
        end
        StClean: state_q <= StWait;
        StWait: if (zb.allDone) begin
          state_q <= StReport;
        end
        StReport: state_q <= StStop;
        // R9: only reset leaves
        StStop: state_q <= StStop;
        default: state_q <= StStop;
      endcase
    end
  end

  // R16: one-cycle zeroize command
  always_ff @(posedge clk) begin
    if (!resetn) begin
      startCmd_q <= 1'b0;
    end else begin
      startCmd_q <= (state_q == StIdle) && violation &&
                    ctrl_q[`BIT_RESP_CLEAN];
    end
  end
  assign zb.start = startCmd_q;

  // R12: abort and clear, held from clean on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clean_q <= 1'b0;
    end else if ((state_q == StIdle) && violation &&
                 ctrl_q[`BIT_RESP_CLEAN]) begin
      clean_q <= 1'b1;
    end
  end
  assign abortOps = clean_q;
  assign keyVaultClear = clean_q;
  // R17: battery-backed key wipe
  assign keyRamClear = clean_q;
  // R22: clear-only fabric and sector registers
  assign regClear = clean_q;
  // R14: security features off
  assign securityOff = clean_q;

  // R15: config status low from clean onward
  always_ff @(posedge clk) begin
    if (!resetn) begin
      configStatusN <= 1'b1;
    end else if ((state_q == StIdle) && violation &&
                 ctrl_q[`BIT_RESP_CLEAN]) begin
      configStatusN <= 1'b0;
    end
  end

  // R18: gate clocks as the last step
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dataClkEn <= 1'b1;
      ctrlClkEn <= 1'b1;
    end else if (state_q == StReport) begin
      dataClkEn <= 1'b0;
      ctrlClkEn <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and status pins
  // ----------------------------------------------------------------
  // R3: detect flags never clear before reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      detect_q <= 1'b0;
      tamperDetectOut <= 1'b0;
    end else begin
      detect_q <= detect_q || violation;
      // R1: pin only when enabled
      tamperDetectOut <= tamperDetectOut ||
                         (violation && ctrl_q[`BIT_DET_PIN]);
    end
  end

  // R13: done only after full pass
  always_ff @(posedge clk) begin
    if (!resetn) begin
      zeroOk_q <= 1'b0;
      zeroizeDoneOut <= 1'b0;
    end else if (state_q == StReport && zb.allPass) begin
      zeroOk_q <= 1'b1;
      // R2: confirm successful response
      zeroizeDoneOut <= zeroizeDoneOut || ctrl_q[`BIT_ZERO_PIN];
    end
  end

  // ----------------------------------------------------------------
  // Memory controller sequencer
  // ----------------------------------------------------------------
  // R11: configuration and processor RAM zeroized
  zeroize_sequencer #(.N(N)) u_seq (
    .clk(clk),
    .resetn(resetn),
    .zb(zb.seq),
    .memStart(memZeroStart),
    .memDone(memZeroDone),
    .memPass(memZeroPass)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_det;
    violation && ctrl_q[`BIT_DET_PIN] |=> tamperDetectOut;
  endproperty
  a_det: assert property (p_det) else $error("detect pin missed"); // R1
  property p_stick;
    tamperDetectOut |=> tamperDetectOut [*8];
  endproperty
  a_stick: assert property (p_stick) else $error("detect pin fell"); // R3
  property p_zstick;
    zeroizeDoneOut |=> zeroizeDoneOut;
  endproperty
  a_zstick: assert property (p_zstick) else $error("done pin fell"); // R3
  property p_resp;
    state_q == StIdle && violation && ctrl_q[`BIT_RESP_CLEAN]
      |=> state_q == StClean ##1 state_q == StWait && !configStatusN;
  endproperty
  a_resp: assert property (p_resp) else $error("no clean response"); // R10
  property p_off;
    state_q == StIdle && !ctrl_q[`BIT_RESP_CLEAN]
      |=> state_q == StIdle && !clean_q;
  endproperty
  a_off: assert property (p_off) else $error("disabled level acted"); // R19
  property p_temp;
    state_q == StIdle && ctrl_q[`BIT_TEMP_EN] && dieTemp > tempHi_q &&
      ctrl_q[`BIT_RESP_CLEAN] |=> state_q == StClean;
  endproperty
  a_temp: assert property (p_temp) else $error("temp trip missed"); // R6
  property p_stop;
    state_q == StReport |=> state_q == StStop && !dataClkEn && !ctrlClkEn;
  endproperty
  a_stop: assert property (p_stop) else $error("clocks not gated"); // R18
  property p_hold;
    state_q == StStop |=> state_q == StStop;
  endproperty
  a_hold: assert property (p_hold) else $error("left stopped state"); // R9
  property p_done;
    $rose(zeroizeDoneOut) |-> $past(zb.allPass) && ctrl_q[`BIT_ZERO_PIN];
  endproperty
  a_done: assert property (p_done) else $error("done without pass"); // R13
  property p_frz;
    state_q != StIdle |=> $stable(ctrl_q) && $stable(voltPct_q);
  endproperty
  a_frz: assert property (p_frz) else $error("settings changed"); // R8
  property p_cln;
    state_q == StClean |-> !configStatusN && keyRamClear && securityOff;
  endproperty
  a_cln: assert property (p_cln) else $error("clean step missing"); // R15
  property p_ord;
    state_q == StClean |-> memZeroStart == '0;
  endproperty
  a_ord: assert property (p_ord) else $error("command before clear"); // R23
  property p_wrblk;
    psel && penable && pwrite && state_q != StIdle |-> pslverr;
  endproperty
  a_wrblk: assert property (p_wrblk) else $error("late write taken"); // R8

  // Main response scenarios and an APB error response
  c_full: cover property (state_q == StReport && zb.allPass);
  c_fail: cover property (state_q == StReport && !zb.allPass);
  c_dis: cover property (tamperDetectOut && state_q == StIdle);
  c_err: cover property (psel && penable && pslverr);
endmodule // tamper_response_controller

// >>> tb/mem_ctrl_model.sv
// Memory controller stand-in answering zeroize commands
`timescale 1ns/1ps
module mem_ctrl_model #(
  parameter int N = 3
)(
  input wire logic clk,
  input wire logic [N-1:0] memStart,
  input wire logic [7:0] lat,
  input wire logic [N-1:0] failMask,
  output logic [N-1:0] memDone,
  output logic [N-1:0] memPass
);
  logic [7:0] cnt [N];
  logic tog = 1'b0;

  // Controller i answers lat+i+1 cycles after its command, pass or fail
  always @(posedge clk) begin
    tog <= ~tog;
    for (int i = 0; i < N; i++) begin
      cnt[i] <= memStart[i] ? cnt[i] + 8'd1 : 8'd0;
      memDone[i] <= memStart[i] && cnt[i] >= lat + 8'(i);
      // Verdict is only meaningful with done; otherwise it wanders
      if (memStart[i] && cnt[i] >= lat + 8'(i)) begin
        memPass[i] <= !failMask[i];
      end else begin
        memPass[i] <= tog;
      end
    end
  end
endmodule // mem_ctrl_model

// >>> tb/tb_tamper_response_controller.sv
// Self-checking bench for the tamper response controller
`timescale 1ns/1ps
`include "tamper_cfg.svh"
module tb_tamper_response_controller
  import tamper_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr;
  logic [31:0] prdata, rd;
  logic [7:0] refClkDev = 8'h00;
  logic [7:0] coreRailDev = 8'h00;
  logic [7:0] mgrRailDev = 8'h00;
  logic [7:0] dieTemp = 8'h80;
  logic [7:0] lat = 8'h00;
  logic [2:0] failMask = 3'h0;
  logic [2:0] memZeroStart, memZeroDone, memZeroPass;
  logic abortOps, keyVaultClear, keyRamClear, regClear, securityOff;
  logic tamperDetectOut, zeroizeDoneOut, configStatusN;
  logic dataClkEn, ctrlClkEn;
  int errTotal = 0;
  int samplesChecked = 0;
  int seed = 19;

  always #25 clk = ~clk;

  tamper_response_controller dut_u (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .refClkDev,
    .coreRailDev, .mgrRailDev, .dieTemp, .memZeroStart, .memZeroDone,
    .memZeroPass, .abortOps, .keyVaultClear, .keyRamClear, .regClear,
    .securityOff, .tamperDetectOut, .zeroizeDoneOut, .configStatusN,
    .dataClkEn, .ctrlClkEn);

  mem_ctrl_model ctl_u (.clk, .memStart(memZeroStart), .lat, .failMask,
    .memDone(memZeroDone), .memPass(memZeroPass));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task results;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic eErr);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    check(pslverr, eErr);
    check(n, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task doReset;
    @(posedge clk);
    resetn <= 1'b0;
    refClkDev <= 8'h00;
    coreRailDev <= 8'h00;
    mgrRailDev <= 8'h00;
    dieTemp <= 8'h80;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check({tamperDetectOut, zeroizeDoneOut}, 0);
    check({configStatusN, dataClkEn, ctrlClkEn}, 3'b111);
    check({abortOps, keyVaultClear, keyRamClear, regClear, securityOff},
          0);
    check(memZeroStart, 0);
  endtask

  // Configure, hold at threshold, then cross it on one monitor
  task runCase(input int k, input logic [6:0] ctl, input logic [2:0] fm);
    logic [7:0] thr;
    logic trip, clean;
    int n;
    thr = 8'd8 + 8'($unsigned($random(seed)) % 150);
    failMask <= fm;
    lat <= 8'($unsigned($random(seed)) % 8);
    doReset;
    apb(1'b1, `OFF_FREQ, {24'h0, thr}, 1'b0);
    apb(1'b1, `OFF_VOLT, {24'h0, thr}, 1'b0);
    apb(1'b1, `OFF_TEMP, {16'h0, thr + 8'd40, thr}, 1'b0);
    refClkDev <= thr;
    coreRailDev <= thr;
    mgrRailDev <= thr;
    dieTemp <= thr;
    apb(1'b1, `OFF_CTRL, {25'h0, ctl}, 1'b0);
    apb(1'b0, `OFF_FREQ, 32'h0, 1'b0);
    check(rd, {24'h0, thr});
    repeat (3) @(posedge clk);
    #1;
    check({tamperDetectOut, configStatusN}, 2'b01);
    @(posedge clk);
    case (k)
      0: refClkDev <= thr + 8'd1;
      1: dieTemp <= thr - 8'd1;
      2: coreRailDev <= thr + 8'd1;
      default: mgrRailDev <= thr + 8'd1;
    endcase
    trip = ctl[k];
    clean = trip & ctl[`BIT_RESP_CLEAN];
    @(posedge clk);
    #1;
    check(tamperDetectOut, trip & ctl[`BIT_DET_PIN]);
    check(configStatusN, !clean);
    check({abortOps, keyVaultClear, keyRamClear, regClear, securityOff},
          {5{clean}});
    check(memZeroStart, 0);
    @(posedge clk);
    #1;
    check(memZeroStart, {3{clean}});
    n = 0;
    while (dataClkEn === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    check({dataClkEn, ctrlClkEn}, {2{!clean}});
    check(zeroizeDoneOut, clean & ctl[`BIT_ZERO_PIN] & (fm == 0));
    if (clean) begin
      apb(1'b1, `OFF_CTRL, 32'h0, 1'b1);
    end
    @(posedge clk);
    refClkDev <= 8'h00;
    coreRailDev <= 8'h00;
    mgrRailDev <= 8'h00;
    dieTemp <= thr + 8'd1;
    repeat (5) @(posedge clk);
    #1;
    check(tamperDetectOut, trip & ctl[`BIT_DET_PIN]);
    check({configStatusN, dataClkEn}, {2{!clean}});
    apb(1'b0, `OFF_STAT, 32'h0, 1'b0);
    check(rd[7:0], {4'h0, clean, clean, clean & (fm == 3'h0), trip});
    $display("case %0d ctl %h done", k, ctl);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    doReset;
    apb(1'b0, `OFF_CTRL, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b0, `OFF_FREQ, 32'h0, 1'b0);
    check(rd, 32'h0000000a);
    apb(1'b0, `OFF_VOLT, 32'h0, 1'b0);
    check(rd, 32'h00000005);
    apb(1'b0, `OFF_TEMP, 32'h0, 1'b0);
    check(rd, 32'h0000ff00);
    apb(1'b0, 8'h14, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `OFF_STAT, 32'hff, 1'b1);
    apb(1'b0, `OFF_STAT, 32'h0, 1'b0);
    check(rd, 32'h0);
    $display("register test done");
    runCase(0, 7'h7f, 3'b000);
    runCase(1, 7'h7f, 3'b010);
    runCase(2, 7'h3f, 3'b000);
    runCase(3, 7'h6f, 3'b000);
    runCase(0, 7'h7e, 3'b000);
    runCase(3, 7'h5f, 3'b100);
    repeat (4) begin
      runCase($unsigned($random(seed)) % 4, 7'($random(seed)),
              3'($random(seed)));
    end
    results;
  end

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    errTotal++;
    results;
  end
endmodule // tb_tamper_response_controller
